// >>> verilog/msl_top.v
// motion stop and limit control with an axi4-lite register slave
// assumes sensor and stop inputs are asynchronous pins; rest on clk_sys
// Contract
// - the stop input during motion brings the motor to a stop.
// - a two-bit setting selects immediate or deceleration for stop and servo-off stop.
// - the blocking-input setting selects immediate (0) or deceleration (1) stop.
// - the limit-sensor setting selects homing use, stops, and stops with alarm.
// - software limits are checked only while coordinates are established.
// - the software limit setting disables, stops, or stops with alarm.
// - signed 32-bit forward and reverse software limits default to max and min.
// - after a limit in one direction motion in the other direction is allowed.
// - the acceleration unit setting selects kHz/s, seconds or ms/kHz.
// - the effective rate is held between 1 Hz/s and 1 GHz/s.
// - a commanded speed below the starting speed starts at the commanded speed.
// - a starting speed default 500 Hz applies to stored-data and continuous macro.
// - a separate jog starting speed from 0 to 4,000,000 Hz defaults to 500 Hz.
// - fast and normal homing have distinct starting speeds with their own ranges.
`timescale 1ns/1ps
`include "msl_consts.vh"
module msl_top (
    input wire clk_sys, // 125 MHz clock
    input wire rst_b, // async reset, active low
    input wire [7:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output wire s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte strobes
    input wire s_axi_wvalid, // write data valid
    output wire s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [7:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output wire s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    input wire stop_input, // operation stop pin
    input wire halt_servo_off_input, // servo-off stop pin
    input wire forward_block_input, // forward blocking pin
    input wire reverse_block_input, // reverse blocking pin
    input wire forward_limit_sensor, // forward limit sensor pin
    input wire reverse_limit_sensor, // reverse limit sensor pin
    input wire motor_running, // motion in progress
    input wire move_forward, // 1: motion is forward
    input wire coords_set, // coordinate system established
    input wire [31:0] cmd_position, // signed command position, steps
    input wire [31:0] cmd_speed, // commanded operating speed, Hz
    input wire [1:0] op_kind, // 0 stored/cont, 1 jog, 2 fast home, 3 home
    output reg stop_now, // immediate stop request
    output reg stop_decel, // deceleration stop request
    output reg servo_off, // servo-off from the synchronised servo-off pin
    output reg alarm, // latched overtravel alarm
    output reg fwd_allowed, // forward motion permitted
    output reg rev_allowed, // reverse motion permitted
    output reg [31:0] start_speed, // effective starting speed, Hz
    output reg [31:0] acc_rate, // clamped acceleration rate
    output reg [31:0] dec_rate, // clamped deceleration rate
    output reg [1:0] acc_unit, // acceleration unit in use
    output reg home_fwd_sensor, // limit sensor used as home sensor
    output reg home_rev_sensor // limit sensor used as home sensor
);

reg [31:0] stopcfg_reg;
reg [31:0] fwdlim_reg;
reg [31:0] revlim_reg;
reg [1:0] accunit_reg;
reg [31:0] accval_reg;
reg [31:0] decval_reg;
reg [31:0] spd_sd_reg;
reg [31:0] spd_jog_reg;
reg [31:0] spd_fast_reg;
reg [31:0] spd_home_reg;
reg fwd_alarm_reg;
reg rev_alarm_reg;
reg [5:0] sync1_reg;
reg [5:0] sync2_reg;
reg aw_got_reg;
reg w_got_reg;
reg [7:0] awaddr_reg;
reg [31:0] wdata_reg;
reg [3:0] wstrb_reg;

// two-flop synchronisers for the six pins
always @(posedge clk_sys or negedge rst_b)
begin
    if (!rst_b)
    begin
        sync1_reg <= 6'h00;
        sync2_reg <= 6'h00;
    end
    else
    begin
        sync1_reg <= {reverse_limit_sensor, forward_limit_sensor, reverse_block_input,
            forward_block_input, halt_servo_off_input, stop_input};
        sync2_reg <= sync1_reg;
    end
end

wire stop_s = sync2_reg[0];
wire soff_s = sync2_reg[1];
wire fblk_s = sync2_reg[2];
wire rblk_s = sync2_reg[3];
wire fls_s = sync2_reg[4];
wire rls_s = sync2_reg[5];
wire [1:0] stop_act = stopcfg_reg[`MSL_F_STOPACT+1:`MSL_F_STOPACT];
wire blk_act = stopcfg_reg[`MSL_F_BLKACT];
wire [2:0] ls_act = stopcfg_reg[`MSL_F_LSACT+2:`MSL_F_LSACT];
wire [2:0] sw_act = stopcfg_reg[`MSL_F_SWACT+2:`MSL_F_SWACT];

// software limit compare, gated by coordinates and setting
wire sw_en = coords_set && (sw_act != 3'h7);
wire sw_fwd_hit = sw_en && ($signed(cmd_position) >= $signed(fwdlim_reg));
wire sw_rev_hit = sw_en && ($signed(cmd_position) <= $signed(revlim_reg));
wire ls_home = (ls_act == 3'h7);
wire ls_fwd_hit = fls_s && !ls_home;
wire ls_rev_hit = rls_s && !ls_home;

// a limit only stops motion heading into it
wire fwd_moving = motor_running && move_forward;
wire rev_moving = motor_running && !move_forward;
wire ls_trip = (ls_fwd_hit && fwd_moving) || (ls_rev_hit && rev_moving);
wire sw_trip = (sw_fwd_hit && fwd_moving) || (sw_rev_hit && rev_moving);
wire blk_trip = (fblk_s && fwd_moving) || (rblk_s && rev_moving);
wire ls_alarm = ls_act[1] && !ls_home;
wire sw_alarm = sw_act[1];
wire alarm_block = (fwd_alarm_reg && fwd_moving) || (rev_alarm_reg && rev_moving);

reg imm_next;
reg dec_next;
always @*
begin
    imm_next = 1'b0;
    dec_next = 1'b0;
    if (motor_running && stop_s)
    begin
        if (stop_act[0])
            dec_next = 1'b1;
        else
            imm_next = 1'b1;
    end
    if (motor_running && soff_s)
    begin
        if (stop_act[1])
            dec_next = 1'b1;
        else
            imm_next = 1'b1;
    end
    if (blk_trip)
    begin
        if (blk_act)
            dec_next = 1'b1;
        else
            imm_next = 1'b1;
    end
    if (ls_trip)
    begin
        if (ls_act[0])
            dec_next = 1'b1;
        else
            imm_next = 1'b1;
    end
    if (sw_trip)
    begin
        if (sw_act[0])
            dec_next = 1'b1;
        else
            imm_next = 1'b1;
    end
    // a decel stop already chosen for this trip keeps its kind
    if (alarm_block && !dec_next)
        imm_next = 1'b1;
    if (imm_next)
        dec_next = 1'b0;
end

// rate clamp into the legal window
function [31:0] clamp_rate;
    input [31:0] v;
    begin
        if (v < `MSL_RATE_MIN)
            clamp_rate = `MSL_RATE_MIN;
        else if (v > `MSL_RATE_MAX)
            clamp_rate = `MSL_RATE_MAX;
        else
            clamp_rate = v;
    end
endfunction

reg [31:0] base_speed;
always @*
begin
    case (op_kind)
        2'h1: base_speed = spd_jog_reg;
        2'h2: base_speed = spd_fast_reg;
        2'h3: base_speed = spd_home_reg;
        default: base_speed = spd_sd_reg;
    endcase
end

// axi4-lite write path
wire do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;
assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1)
            if (st[i])
                merge[i*8 +: 8] = nw[i*8 +: 8];
    end
endfunction

function [31:0] clamp_spd;
    input [31:0] v;
    input lo1;
    begin
        if (v > `MSL_SPD_MAX)
            clamp_spd = `MSL_SPD_MAX;
        else if (lo1 && v == 32'h0)
            clamp_spd = 32'h0000_0001;
        else
            clamp_spd = v;
    end
endfunction

wire [31:0] wv_stop = merge(stopcfg_reg, wdata_reg, wstrb_reg);
wire [31:0] wv_unit = merge({30'h0, accunit_reg}, wdata_reg, wstrb_reg);

always @(posedge clk_sys or negedge rst_b)
begin
    if (!rst_b)
    begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        awaddr_reg <= 8'h00;
        wdata_reg <= 32'h0;
        wstrb_reg <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
        stopcfg_reg <= `MSL_RST_STOPCFG;
        fwdlim_reg <= `MSL_RST_FWDLIM;
        revlim_reg <= `MSL_RST_REVLIM;
        accunit_reg <= `MSL_RST_ACCUNIT;
        accval_reg <= `MSL_RST_ACCVAL;
        decval_reg <= `MSL_RST_ACCVAL;
        spd_sd_reg <= `MSL_RST_SPD;
        spd_jog_reg <= `MSL_RST_SPD;
        spd_fast_reg <= `MSL_RST_SPD;
        spd_home_reg <= `MSL_RST_SPD;
        fwd_alarm_reg <= 1'b0;
        rev_alarm_reg <= 1'b0;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        // alarm clear first so a new trip in the same cycle wins
        if (do_write)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            case (awaddr_reg & 8'hFC)
                `MSL_OFF_STOPCFG: stopcfg_reg <= wv_stop;
                `MSL_OFF_FWDLIM: fwdlim_reg <= merge(fwdlim_reg, wdata_reg, wstrb_reg);
                `MSL_OFF_REVLIM: revlim_reg <= merge(revlim_reg, wdata_reg, wstrb_reg);
                `MSL_OFF_ACCUNIT:
                    if (wv_unit[1:0] != 2'h3)
                        accunit_reg <= wv_unit[1:0];
                `MSL_OFF_ACCVAL:
                    accval_reg <= clamp_rate(merge(accval_reg, wdata_reg, wstrb_reg));
                `MSL_OFF_DECVAL:
                    decval_reg <= clamp_rate(merge(decval_reg, wdata_reg, wstrb_reg));
                `MSL_OFF_SPD_SD:
                    spd_sd_reg <= clamp_spd(merge(spd_sd_reg, wdata_reg, wstrb_reg), 1'b0);
                `MSL_OFF_SPD_JOG:
                    spd_jog_reg <= clamp_spd(merge(spd_jog_reg, wdata_reg, wstrb_reg), 1'b0);
                `MSL_OFF_SPD_FAST:
                    spd_fast_reg <= clamp_spd(merge(spd_fast_reg, wdata_reg, wstrb_reg), 1'b0);
                `MSL_OFF_SPD_HOME:
                    spd_home_reg <= clamp_spd(merge(spd_home_reg, wdata_reg, wstrb_reg), 1'b1);
                `MSL_OFF_CTRL:
                    if (wstrb_reg[0] && wdata_reg[0])
                    begin
                        fwd_alarm_reg <= 1'b0;
                        rev_alarm_reg <= 1'b0;
                    end
                `MSL_OFF_STATUS: s_axi_bresp <= 2'h0;
                default: s_axi_bresp <= 2'h2;
            endcase
        end
        // latched alarm per direction, set wins over clear
        if ((ls_alarm && ls_fwd_hit && fwd_moving) || (sw_alarm && sw_fwd_hit && fwd_moving))
            fwd_alarm_reg <= 1'b1;
        if ((ls_alarm && ls_rev_hit && rev_moving) || (sw_alarm && sw_rev_hit && rev_moving))
            rev_alarm_reg <= 1'b1;
    end
end

// axi4-lite read path
reg [31:0] rd_mux;
reg rd_err;
always @*
begin
    rd_err = 1'b0;
    case (s_axi_araddr & 8'hFC)
        `MSL_OFF_STOPCFG: rd_mux = stopcfg_reg;
        `MSL_OFF_FWDLIM: rd_mux = fwdlim_reg;
        `MSL_OFF_REVLIM: rd_mux = revlim_reg;
        `MSL_OFF_ACCUNIT: rd_mux = {30'h0, accunit_reg};
        `MSL_OFF_ACCVAL: rd_mux = accval_reg;
        `MSL_OFF_DECVAL: rd_mux = decval_reg;
        `MSL_OFF_SPD_SD: rd_mux = spd_sd_reg;
        `MSL_OFF_SPD_JOG: rd_mux = spd_jog_reg;
        `MSL_OFF_SPD_FAST: rd_mux = spd_fast_reg;
        `MSL_OFF_SPD_HOME: rd_mux = spd_home_reg;
        `MSL_OFF_CTRL: rd_mux = 32'h0;
        `MSL_OFF_STATUS: rd_mux = {22'h0, sync2_reg, rev_alarm_reg, fwd_alarm_reg,
            stop_decel, stop_now};
        default:
        begin
            rd_mux = 32'h0;
            rd_err = 1'b1;
        end
    endcase
end

always @(posedge clk_sys or negedge rst_b)
begin
    if (!rst_b)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
    end
    else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
end

// registered outputs
always @(posedge clk_sys or negedge rst_b)
begin
    if (!rst_b)
    begin
        stop_now <= 1'b0;
        stop_decel <= 1'b0;
        servo_off <= 1'b0;
        alarm <= 1'b0;
        fwd_allowed <= 1'b1;
        rev_allowed <= 1'b1;
        start_speed <= `MSL_RST_SPD;
        acc_rate <= `MSL_RST_ACCVAL;
        dec_rate <= `MSL_RST_ACCVAL;
        acc_unit <= `MSL_RST_ACCUNIT;
        home_fwd_sensor <= 1'b0;
        home_rev_sensor <= 1'b0;
    end
    else
    begin
        stop_now <= imm_next;
        stop_decel <= dec_next;
        servo_off <= soff_s;
        alarm <= fwd_alarm_reg || rev_alarm_reg;
        fwd_allowed <= !(fblk_s || ls_fwd_hit || sw_fwd_hit || fwd_alarm_reg);
        rev_allowed <= !(rblk_s || ls_rev_hit || sw_rev_hit || rev_alarm_reg);
        start_speed <= (cmd_speed < base_speed) ? cmd_speed : base_speed;
        acc_rate <= accval_reg;
        dec_rate <= decval_reg;
        acc_unit <= accunit_reg;
        home_fwd_sensor <= ls_home && fls_s;
        home_rev_sensor <= ls_home && rls_s;
    end
end

endmodule // msl_top

// >>> verilog/msl_consts.vh
// constants for the motion stop and limit block
// included by msl_top.v; definitions only
`ifndef MSL_CONSTS_VH
`define MSL_CONSTS_VH
// register byte offsets
`define MSL_OFF_STOPCFG 8'h00
`define MSL_OFF_FWDLIM 8'h04
`define MSL_OFF_REVLIM 8'h08
`define MSL_OFF_ACCUNIT 8'h0C
`define MSL_OFF_ACCVAL 8'h10
`define MSL_OFF_DECVAL 8'h14
`define MSL_OFF_SPD_SD 8'h18
`define MSL_OFF_SPD_JOG 8'h1C
`define MSL_OFF_SPD_FAST 8'h20
`define MSL_OFF_SPD_HOME 8'h24
`define MSL_OFF_CTRL 8'h28
`define MSL_OFF_STATUS 8'h2C
// stop config field positions
`define MSL_F_STOPACT 0
`define MSL_F_BLKACT 2
`define MSL_F_LSACT 4
`define MSL_F_SWACT 8
// stop config reset: stop=3 blk=1 ls=2 sw=3
`define MSL_RST_STOPCFG 32'h0000_0327
`define MSL_RST_FWDLIM 32'h7FFF_FFFF
`define MSL_RST_REVLIM 32'h8000_0000
`define MSL_RST_ACCUNIT 2'h0
`define MSL_RST_ACCVAL 32'h000F_4240
`define MSL_RST_SPD 32'h0000_01F4
`define MSL_SPD_MAX 32'h003D_0900
`define MSL_RATE_MIN 32'h0000_0001
`define MSL_RATE_MAX 32'h3B9A_CA00
// rate 1.0 kHz/s = 1000 in units of 0.001
`define MSL_ACC_UNIT_RATE 2'h0
`define MSL_ACC_UNIT_TIME 2'h1
`define MSL_ACC_UNIT_INV 2'h2
`endif

// >>> test/msl_top_asserts.sv
// checker for the stop and limit block, bound to its top ports
// assumes a single clk_sys domain with the active-low rst_b
`timescale 1ns/1ps
module msl_top_chk (
    input wire clk_sys, // clock
    input wire rst_b, // reset, active low
    input wire s_axi_arvalid, // read address valid
    input wire s_axi_arready, // read address ready
    input wire s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    input wire s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [31:0] cmd_speed, // commanded speed
    input wire stop_now, // immediate stop
    input wire stop_decel, // decel stop
    input wire alarm, // latched alarm
    input wire fwd_allowed, // forward permitted
    input wire rev_allowed, // reverse permitted
    input wire [31:0] start_speed, // starting speed
    input wire [31:0] acc_rate, // accel rate
    input wire [31:0] dec_rate // decel rate
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence r_waiting;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    chk_stop_exclusive: assert property (!(stop_now && stop_decel))
        else $error("both stop kinds raised");
    chk_start_capped: assert property ($past(rst_b) |-> start_speed <= $past(cmd_speed))
        else $error("start speed above commanded speed");
    chk_rate_range: assert property (acc_rate >= 32'h1 && acc_rate <= 32'h3B9A_CA00
        && dec_rate >= 32'h1 && dec_rate <= 32'h3B9A_CA00) else $error("rate out of range");
    chk_alarm_latched: assert property (alarm && !s_axi_bvalid |=> alarm || s_axi_bvalid)
        else $error("alarm dropped without clear");
    chk_alarm_blocks: assert property (alarm |-> ##[0:1] (!fwd_allowed || !rev_allowed))
        else $error("alarm does not block motion");
    chk_read_answer: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_read_hold: assert property (r_waiting |=> s_axi_rvalid)
        else $error("read data dropped early");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    chk_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read data without request");
endmodule // msl_top_chk
bind msl_top msl_top_chk chk (.clk_sys, .rst_b, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .cmd_speed, .stop_now, .stop_decel, .alarm,
    .fwd_allowed, .rev_allowed, .start_speed, .acc_rate, .dec_rate);

// >>> test/msl_far_side.sv
// far-side model: limit sensors and host stop switches
// assumes pin_req is updated by the bench at clk_sys edges
`timescale 1ns/1ps
module msl_far_side (
    input wire clk_sys, // pacing clock
    input wire [5:0] pin_req, // stop_input,halt_servo_off_input,fblk,rblk,fls,rls
    output reg stop_input = 1'b0, // operation stop pin
    output reg halt_servo_off_input = 1'b0, // servo-off stop pin
    output reg forward_block_input = 1'b0, // forward blocking pin
    output reg reverse_block_input = 1'b0, // reverse blocking pin
    output reg forward_limit_sensor = 1'b0, // forward limit sensor
    output reg reverse_limit_sensor = 1'b0 // reverse limit sensor
);
    // switches move off the edge; stop settings are picked by the host
    always @(posedge clk_sys)
    begin
        #2;
        {reverse_limit_sensor, forward_limit_sensor, reverse_block_input, forward_block_input,
            halt_servo_off_input, stop_input} <= pin_req;
    end
endmodule // msl_far_side

// >>> test/motion_stop_and_limit_control_tb_top.sv
// testbench for the stop and limit block
// assumes msl_top, its checker and the far-side model are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module motion_stop_and_limit_control_tb_top;
    logic clk_sys = 0, rst_b = 0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, cmd_position = 32'h0, cmd_speed = 32'h0, rd_data;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, motor_running = 0, move_forward = 0, coords_set = 0;
    logic [1:0] op_kind = 2'h0, rd_resp;
    logic [5:0] pin_req = 6'h0;
    wire stop_input, halt_servo_off_input, forward_block_input, reverse_block_input;
    wire forward_limit_sensor, reverse_limit_sensor, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid, stop_now, stop_decel, servo_off, alarm, fwd_allowed;
    wire rev_allowed, home_fwd_sensor, home_rev_sensor;
    wire [1:0] s_axi_bresp, s_axi_rresp, acc_unit;
    wire [31:0] s_axi_rdata, start_speed, acc_rate, dec_rate;
    int mismatches = 0, n_compared = 0, i;
    logic [31:0] sp [4];
    always #4 clk_sys = ~clk_sys;
    msl_top dut (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .stop_input, .halt_servo_off_input, .forward_block_input,
        .reverse_block_input, .forward_limit_sensor, .reverse_limit_sensor, .motor_running,
        .move_forward, .coords_set, .cmd_position, .cmd_speed, .op_kind, .stop_now, .stop_decel,
        .servo_off, .alarm, .fwd_allowed, .rev_allowed, .start_speed, .acc_rate, .dec_rate,
        .acc_unit, .home_fwd_sensor, .home_rev_sensor);
    msl_far_side far (.clk_sys, .pin_req, .stop_input, .halt_servo_off_input,
        .forward_block_input, .reverse_block_input, .forward_limit_sensor, .reverse_limit_sensor);
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic done;
        begin
            done = 0;
            @(posedge clk_sys);
            if (w)
            begin
                s_axi_awaddr <= a;
                s_axi_wdata <= d;
                s_axi_awvalid <= 1;
                s_axi_wvalid <= 1;
                s_axi_bready <= 1;
            end
            else
            begin
                s_axi_araddr <= a;
                s_axi_arvalid <= 1;
                s_axi_rready <= 1;
            end
            while (!done)
            begin
                @(posedge clk_sys);
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
                if (s_axi_bready && s_axi_bvalid || s_axi_rready && s_axi_rvalid)
                begin
                    s_axi_bready <= 0;
                    s_axi_rready <= 0;
                    rd_data = s_axi_rdata;
                    rd_resp = w ? s_axi_bresp : s_axi_rresp;
                    done = 1;
                end
            end
            #1;
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        bus(0, a, 32'h0);
        `CHK("register read", e, rd_data)
    endtask
    task cfg(input logic [1:0] s, input logic b, input logic [2:0] l, input logic [2:0] w);
        bus(1, 8'h00, {21'h0, w, 1'b0, l, 1'b0, b, s});
    endtask
    // pins need two sync flops plus the output register
    task step(input logic [5:0] p);
        @(posedge clk_sys);
        pin_req <= p;
        repeat (5) @(posedge clk_sys);
        #1;
    endtask
    task so(input logic n, input logic d, input logic al);
        `CHK("stop_now", n, stop_now)
        `CHK("stop_decel", d, stop_decel)
        `CHK("alarm", al, alarm)
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        mismatches++;
        print_verdict;
    end
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1;
        #1;
        `CHK("start_speed", 32'h1F4, start_speed)
        `CHK("acc_rate", 32'hF_4240, acc_rate)
        rchk(8'h00, 32'h327);
        rchk(8'h04, 32'h7FFF_FFFF);
        rchk(8'h08, 32'h8000_0000);
        for (i = 0; i < 4; i++) rchk(8'h18 + 8'(4 * i), 32'h1F4);
        bus(0, 8'h30, 32'h0);
        `CHK("unmapped resp", 2'h2, rd_resp)
        `CHK("unmapped data", 32'h0, rd_data)
        bus(1, 8'h30, 32'h0);
        `CHK("unmapped bresp", 2'h2, rd_resp)
        step(6'h01);
        so(0, 0, 0);
        @(posedge clk_sys);
        motor_running <= 1;
        move_forward <= 1;
        for (i = 0; i < 4; i++)
        begin
            cfg(i[1:0], 1, 2, 3);
            step(6'h01);
            so(!i[0], i[0], 0);
            step(6'h02);
            so(!i[1], i[1], 0);
            `CHK("servo_off", 1'b1, servo_off)
            step(6'h00);
        end
        for (i = 0; i < 2; i++)
        begin
            cfg(3, i[0], 2, 3);
            step(6'h04);
            so(!i[0], i[0], 0);
            step(6'h08);
            so(0, 0, 0);
        end
        for (i = 0; i < 4; i++)
        begin
            cfg(3, 1, i[2:0], 3);
            step(6'h10);
            so(!i[0], i[0], i[1]);
            `CHK("rev_allowed", 1'b1, rev_allowed)
            step(6'h00);
            `CHK("alarm", i[1], alarm)
            `CHK("fwd_allowed", !i[1], fwd_allowed)
            bus(1, 8'h28, 32'h1);
            `CHK("alarm", 1'b0, alarm)
        end
        cfg(3, 1, 7, 3);
        step(6'h10);
        so(0, 0, 0);
        `CHK("home_fwd_sensor", 1'b1, home_fwd_sensor)
        step(6'h20);
        so(0, 0, 0);
        `CHK("home_rev_sensor", 1'b1, home_rev_sensor)
        `CHK("home_fwd_sensor", 1'b0, home_fwd_sensor)
        step(6'h00);
        bus(1, 8'h04, 32'h64);
        cmd_position <= 32'hC8;
        step(6'h00);
        so(0, 0, 0);
        for (i = 0; i < 5; i++)
        begin
            cfg(3, 1, 2, (i == 4) ? 3'h7 : i[2:0]);
            coords_set <= 1;
            step(6'h00);
            so(i < 4 && !i[0], i < 4 && i[0], i < 4 && i[1]);
            coords_set <= 0;
            bus(1, 8'h28, 32'h1);
        end
        for (i = 0; i < 3; i++)
        begin
            bus(1, 8'h0C, i);
            rchk(8'h0C, i);
            `CHK("acc_unit", i[1:0], acc_unit)
        end
        bus(1, 8'h10, 32'h0);
        rchk(8'h10, 32'h1);
        bus(1, 8'h14, 32'hFFFF_FFFF);
        rchk(8'h14, 32'h3B9A_CA00);
        `CHK("dec_rate", 32'h3B9A_CA00, dec_rate)
        sp = '{32'h3E8, 32'h3D_0900, 32'h0, 32'h1};
        bus(1, 8'h18, 32'h3E8);
        bus(1, 8'h1C, 32'h4C_4B40);
        bus(1, 8'h20, 32'h0);
        bus(1, 8'h24, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            rchk(8'h18 + 8'(4 * i), sp[i]);
            op_kind <= i[1:0];
            cmd_speed <= 32'h3D_0A00;
            repeat (2) @(posedge clk_sys);
            #1;
            `CHK("start_speed", sp[i], start_speed)
        end
        cmd_speed <= 32'h0;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("start_speed", 32'h0, start_speed)
        print_verdict;
    end
endmodule // motion_stop_and_limit_control_tb_top
